// [common/slc_pkg.sv]
// Constants shared by the secure-launch command and status register bank.
// Assumes a 64-bit memory-cycle port with byte enables and 8-byte aligned offsets.
package slc_pkg;
    // Window bases (upper address half)
    localparam logic [15:0] SLC_PRIV_BASE      = 16'hfed2;
    localparam logic [15:0] SLC_PUB_BASE       = 16'hfed3;
    // Register offsets
    localparam logic [15:0] SLC_OFF_STATUS     = 16'h0000;
    localparam logic [15:0] SLC_OFF_ERROR      = 16'h0008;
    localparam logic [15:0] SLC_OFF_PRESENT    = 16'h0010;
    localparam logic [15:0] SLC_OFF_JOINED     = 16'h0020;
    localparam logic [15:0] SLC_OFF_SCRATCH    = 16'h0030;
    localparam logic [15:0] SLC_OFF_PLAT_RST   = 16'h0038;
    localparam logic [15:0] SLC_OFF_PRIV_CLOSE = 16'h0048;
    localparam logic [15:0] SLC_OFF_VERSION    = 16'h0100;
    localparam logic [15:0] SLC_OFF_BASE_LOCK  = 16'h0230;
    localparam logic [15:0] SLC_OFF_BASE_UNLK  = 16'h0238;
    localparam logic [15:0] SLC_OFF_MEM_ENABLE = 16'h00b0;
    localparam logic [15:0] SLC_OFF_PRES_SET   = 16'h00c0;
    localparam logic [15:0] SLC_OFF_PRES_CLR   = 16'h00c8;
    localparam logic [15:0] SLC_OFF_JOIN_SET   = 16'h00d0;
    localparam logic [15:0] SLC_OFF_JOIN_CLR   = 16'h00d8;
    localparam logic [15:0] SLC_OFF_ERR_SET    = 16'h00e0;
    localparam logic [15:0] SLC_OFF_PRIV_OPEN  = 16'h00e8;
    localparam logic [15:0] SLC_OFF_MCFG_CHK   = 16'h00f0;
    localparam logic [15:0] SLC_OFF_MCFG_UNLK  = 16'h00f8;
    // Status register bit positions
    localparam int SLC_ST_MCFG_CHECKED = 11;
    localparam int SLC_ST_PRIV_OPEN    = 7;
    localparam int SLC_ST_MCFG_LOCKED  = 6;
    localparam int SLC_ST_BASE_LOCKED  = 5;
    localparam int SLC_ST_EXIT_DONE    = 1;
    localparam int SLC_ST_ENTRY_DONE   = 0;
    // Error register bit positions
    localparam int SLC_ER_WAKE   = 6;
    localparam int SLC_ER_ALIAS  = 5;
    localparam int SLC_ER_SW4    = 4;
    localparam int SLC_ER_SW3    = 3;
    localparam int SLC_ER_ATTACK = 2;
    localparam int SLC_ER_ROGUE  = 1;
    localparam int SLC_ER_POISON = 0;
    // Error bits that software clears by writing one
    localparam logic [7:0] SLC_ER_W1C_MASK  = 8'h7e;
    // Error bits that the error-set port may set
    localparam logic [7:0] SLC_ER_SET_MASK  = 8'h1c;
    // Reset values
    localparam logic [7:0]  SLC_ERROR_RST   = 8'h00;
    localparam logic [63:0] SLC_MASK_RST    = 64'h0;
    localparam logic [31:0] SLC_SCRATCH_RST = 32'h0;
    // One-byte command access lane pattern
    localparam logic [7:0]  SLC_BE_BYTE0    = 8'h01;
    // Arbitrary neutral chipset revision value
    localparam logic [7:0]  SLC_VERSION_DEF = 8'h01;
endpackage : slc_pkg

// [hw/slc_regs.sv]
// Secure-launch command/status register bank behind a memory-cycle port.
// Assumes one 50 MHz clock, one access per cycle, cycles synchronous to clk.
module slc_regs
    import slc_pkg::*;
#(
    parameter logic [7:0] CHIPSET_VERSION = SLC_VERSION_DEF
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        pci_rst,
    input  wire logic        pwrgood_rst,
    input  wire logic        mem_req,
    input  wire logic        mem_write,
    input  wire logic        mem_special,
    input  wire logic [31:0] mem_addr,
    input  wire logic [7:0]  mem_be,
    input  wire logic [63:0] mem_wdata,
    input  wire logic        memcfg_lock_evt,
    input  wire logic        alias_fault_evt,
    input  wire logic        illegal_dram_read_evt,
    input  wire logic        improper_exit_evt,
    input  wire logic        poison_cycle_evt,
    input  wire logic        ack_secrets_held,
    input  wire logic        ack_no_secrets,
    output logic             rd_valid,
    output logic [63:0]      rd_data,
    output logic             platform_reset_req,
    output logic             remap_lock,
    output logic             base_lock,
    output logic             mem_block,
    output logic             poisoned
);

    // Window decode
    logic        in_special;
    logic        in_private;
    logic        in_public;
    logic        priv_ok;
    logic [15:0] offs;
    logic [63:0] lane_mask;
    logic        wr_priv;
    logic        byte_cmd;
    logic        status_rd;

    // Status and mask state
    logic        mem_config_checked_flag;
    logic        private_open_flag;
    logic        memcfg_locked_flag;
    logic        base_locked_flag;
    logic        exit_done_flag;
    logic        entry_done_flag;
    logic [63:0] present_thread_mask;
    logic [63:0] joined_thread_mask;
    logic [7:0]  error_status;
    logic [31:0] diag_scratch_code;
    logic        after_reset;
    logic [31:0] status_word;
    logic [63:0] next_rd_data;

    // Window selection; ordinary private cycles need the private space open
    assign in_special = mem_addr[31:16] == SLC_PRIV_BASE && mem_special;
    assign in_private = mem_addr[31:16] == SLC_PRIV_BASE && !mem_special
                        && private_open_flag;
    assign in_public  = mem_addr[31:16] == SLC_PUB_BASE;
    assign priv_ok    = in_special || in_private;
    assign offs       = {mem_addr[15:3], 3'b000};
    assign wr_priv    = mem_req && mem_write && priv_ok;
    assign byte_cmd   = mem_be == SLC_BE_BYTE0;
    assign status_rd  = mem_req && !mem_write && (priv_ok || in_public)
                        && offs == SLC_OFF_STATUS;

    // Byte enables widened to a bit mask
    genvar lane;
    generate
        for (lane = 0; lane < 8; lane++)
        begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{mem_be[lane]}};
        end
    endgenerate

    // Derived join flags
    assign exit_done_flag  = joined_thread_mask == SLC_MASK_RST;
    assign entry_done_flag = joined_thread_mask == present_thread_mask
                             && joined_thread_mask != SLC_MASK_RST;

    // Status word assembly
    always_comb
    begin
        status_word                      = 32'h0000_0000;
        status_word[SLC_ST_MCFG_CHECKED] = mem_config_checked_flag;
        status_word[SLC_ST_PRIV_OPEN]    = private_open_flag;
        status_word[SLC_ST_MCFG_LOCKED]  = memcfg_locked_flag;
        status_word[SLC_ST_BASE_LOCKED]  = base_locked_flag;
        status_word[SLC_ST_EXIT_DONE]    = exit_done_flag;
        status_word[SLC_ST_ENTRY_DONE]   = entry_done_flag;
    end

    // Config-checked flag, cleared by PCI reset
    always_ff @(posedge clk or posedge pci_rst)
    begin
        if (pci_rst)
            mem_config_checked_flag <= 1'b0;
        else if (wr_priv && byte_cmd && offs == SLC_OFF_MCFG_CHK)
            mem_config_checked_flag <= 1'b1;
        else if (wr_priv && byte_cmd && offs == SLC_OFF_MCFG_UNLK)
            mem_config_checked_flag <= 1'b0;
    end

    // Private-open flag; open only by special cycles once closed
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            private_open_flag <= 1'b0;
        else if (wr_priv && byte_cmd && offs == SLC_OFF_PRIV_OPEN)
            private_open_flag <= 1'b1;
        else if (wr_priv && byte_cmd && offs == SLC_OFF_PRIV_CLOSE)
            private_open_flag <= 1'b0;
    end

    // Memory-config lock flag; lock event wins over unlock
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            memcfg_locked_flag <= 1'b0;
        else if (memcfg_lock_evt)
            memcfg_locked_flag <= 1'b1;
        else if (wr_priv && byte_cmd && offs == SLC_OFF_MCFG_UNLK)
            memcfg_locked_flag <= 1'b0;
    end

    // Base lock flag
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            base_locked_flag <= 1'b0;
        else if (wr_priv && byte_cmd && offs == SLC_OFF_BASE_LOCK)
            base_locked_flag <= 1'b1;
        else if (wr_priv && byte_cmd && offs == SLC_OFF_BASE_UNLK)
            base_locked_flag <= 1'b0;
    end

    // Lock outputs to the remap and base register owners
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            remap_lock <= 1'b0;
            base_lock  <= 1'b0;
        end
        else
        begin
            remap_lock <= memcfg_locked_flag;
            base_lock  <= base_locked_flag;
        end
    end

    // Present mask, only through its set and clear ports
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            present_thread_mask <= SLC_MASK_RST;
        else if (wr_priv && offs == SLC_OFF_PRES_SET)
            present_thread_mask <= present_thread_mask | (mem_wdata & lane_mask);
        else if (wr_priv && offs == SLC_OFF_PRES_CLR)
            present_thread_mask <= present_thread_mask & ~(mem_wdata & lane_mask);
    end

    // Joined mask, only through its set and clear ports
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            joined_thread_mask <= SLC_MASK_RST;
        else if (wr_priv && offs == SLC_OFF_JOIN_SET)
            joined_thread_mask <= joined_thread_mask | (mem_wdata & lane_mask);
        else if (wr_priv && offs == SLC_OFF_JOIN_CLR)
            joined_thread_mask <= joined_thread_mask & ~(mem_wdata & lane_mask);
    end

    // Error status: power-good reset only, sets win over clears
    always_ff @(posedge clk or posedge pwrgood_rst)
    begin
        if (pwrgood_rst)
            error_status <= SLC_ERROR_RST;
        else
        begin
            if (wr_priv && offs == SLC_OFF_ERROR)
                error_status <= error_status
                                & ~(mem_wdata[7:0] & lane_mask[7:0]
                                    & SLC_ER_W1C_MASK);
            if (wr_priv && offs == SLC_OFF_ERR_SET)
                error_status[SLC_ER_SW4:SLC_ER_ATTACK] <=
                    error_status[SLC_ER_SW4:SLC_ER_ATTACK]
                    | mem_wdata[SLC_ER_SW4:SLC_ER_ATTACK];
            if (ack_no_secrets)
                error_status[SLC_ER_WAKE] <= 1'b0;
            if (ack_secrets_held)
                error_status[SLC_ER_WAKE] <= 1'b1;
            if (alias_fault_evt)
                error_status[SLC_ER_ALIAS] <= 1'b1;
            if (illegal_dram_read_evt)
                error_status[SLC_ER_ATTACK] <= 1'b1;
            if (improper_exit_evt)
                error_status[SLC_ER_ROGUE] <= 1'b1;
            if (poison_cycle_evt)
                error_status[SLC_ER_POISON] <= 1'b1;
        end
    end

    // Scratch code, power-good reset only, lanes 0 to 3
    always_ff @(posedge clk or posedge pwrgood_rst)
    begin
        if (pwrgood_rst)
            diag_scratch_code <= SLC_SCRATCH_RST;
        else if (wr_priv && offs == SLC_OFF_SCRATCH)
            diag_scratch_code <= (diag_scratch_code & ~lane_mask[31:0])
                                 | (mem_wdata[31:0] & lane_mask[31:0]);
    end

    // Post-reset window in which a wake error blocks memory
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            after_reset <= 1'b1;
        else if (wr_priv && byte_cmd && offs == SLC_OFF_MEM_ENABLE)
            after_reset <= 1'b0;
    end

    // Memory block and poison outputs
    always_ff @(posedge clk or posedge pwrgood_rst)
    begin
        if (pwrgood_rst)
        begin
            mem_block <= 1'b0;
            poisoned  <= 1'b0;
        end
        else
        begin
            mem_block <= after_reset && error_status[SLC_ER_WAKE];
            poisoned  <= error_status[SLC_ER_POISON];
        end
    end

    // Platform reset request, one cycle per command
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            platform_reset_req <= 1'b0;
        else
            platform_reset_req <= wr_priv && byte_cmd
                                  && offs == SLC_OFF_PLAT_RST;
    end

    // Read mux; public sees a read-only subset
    always_comb
    begin
        next_rd_data = 64'h0;
        if (priv_ok || in_public)
        begin
            if (offs == SLC_OFF_STATUS)
                next_rd_data = {32'h0, status_word};
            else if (offs == SLC_OFF_ERROR)
                next_rd_data = {56'h0, error_status};
            else if (offs == SLC_OFF_PRESENT)
                next_rd_data = present_thread_mask;
            else if (offs == SLC_OFF_JOINED)
                next_rd_data = joined_thread_mask;
            else if (offs == SLC_OFF_SCRATCH)
                next_rd_data = {32'h0, diag_scratch_code & lane_mask[31:0]};
            else if (offs == SLC_OFF_VERSION && priv_ok)
                next_rd_data = {56'h0, CHIPSET_VERSION};
        end
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_valid <= 1'b0;
            rd_data  <= 64'h0;
        end
        else
        begin
            rd_valid <= mem_req && !mem_write;
            rd_data  <= (mem_req && !mem_write) ? next_rd_data : 64'h0;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst || pwrgood_rst || pci_rst);

    // Join flags as seen through a status read, against the masks
    exit_done_a: assert property (status_rd |=>
        rd_data[SLC_ST_EXIT_DONE] == ($past(joined_thread_mask) == 64'h0))
        else $error("exit flag disagrees with joined mask");
    entry_done_a: assert property (status_rd |=>
        rd_data[SLC_ST_ENTRY_DONE] == ($past(joined_thread_mask) != 64'h0
        && $past(joined_thread_mask) == $past(present_thread_mask)))
        else $error("entry flag disagrees with the masks");
    // Window and command effects
    public_write_a: assert property (mem_req && mem_write && in_public |=>
        $stable(error_status) && $stable(diag_scratch_code) && !platform_reset_req)
        else $error("public write changed state");
    plat_reset_a: assert property (wr_priv && byte_cmd && offs == SLC_OFF_PLAT_RST
        |=> platform_reset_req ##1 !platform_reset_req)
        else $error("platform reset pulse wrong");
    close_private_a: assert property (wr_priv && byte_cmd && offs == SLC_OFF_PRIV_CLOSE
        |=> !private_open_flag)
        else $error("private space still open after close");
    cfg_checked_a: assert property (wr_priv && byte_cmd && offs == SLC_OFF_MCFG_CHK
        |=> mem_config_checked_flag)
        else $error("config-checked command not recorded");
    // Error register sets, clears and sticky poison
    poison_hold_a: assert property (error_status[SLC_ER_POISON]
        |=> error_status[SLC_ER_POISON] ##1 poisoned)
        else $error("poison flag dropped");
    alias_set_a: assert property (alias_fault_evt |=> error_status[SLC_ER_ALIAS])
        else $error("alias fault not recorded");
    rogue_set_a: assert property (improper_exit_evt |=> error_status[SLC_ER_ROGUE])
        else $error("improper exit not recorded");
    err_set_a: assert property (wr_priv && offs == SLC_OFF_ERR_SET && mem_wdata[SLC_ER_SW4]
        |=> error_status[SLC_ER_SW4])
        else $error("error-set port bit 4 ignored");
    err_clear_a: assert property (wr_priv && offs == SLC_OFF_ERROR && mem_be[0]
        && mem_wdata[SLC_ER_ATTACK] && !illegal_dram_read_evt |=> !error_status[SLC_ER_ATTACK])
        else $error("error bit not cleared by a one");
    wake_set_a: assert property (ack_secrets_held |=> error_status[SLC_ER_WAKE])
        else $error("secrets acknowledgement not recorded");
    mem_block_a: assert property (after_reset && error_status[SLC_ER_WAKE] |=> mem_block)
        else $error("memory not blocked on wake error");
    // Lock outputs and read answer
    remap_lock_a: assert property (memcfg_lock_evt |=> memcfg_locked_flag ##1 remap_lock)
        else $error("remap lock not raised");
    base_lock_a: assert property (wr_priv && byte_cmd && offs == SLC_OFF_BASE_LOCK
        |=> base_locked_flag ##1 base_lock)
        else $error("base lock not raised");
    read_answer_a: assert property (mem_req && !mem_write |=> rd_valid)
        else $error("read not answered in one cycle");

    // Main scenarios
    entry_cov_c: cover property (entry_done_flag ##1 !entry_done_flag);
    close_cov_c: cover property (private_open_flag ##1 !private_open_flag);
    err_clear_c: cover property (error_status[SLC_ER_ATTACK] ##1 !error_status[SLC_ER_ATTACK]);
    plat_rst_c:  cover property (platform_reset_req);
    wake_blk_c:  cover property (mem_block ##1 !mem_block);

endmodule : slc_regs

// [dv/slc_host.sv]
// Processor-thread model issuing memory cycles to the register bank.
// Assumes the bench calls access() and supplies the clock.
module slc_host
(
    input  wire logic        clk,
    input  wire logic        rd_valid,
    input  wire logic [63:0] rd_data,
    output logic             mem_req,
    output logic             mem_write,
    output logic             mem_special,
    output logic [31:0]      mem_addr,
    output logic [7:0]       mem_be,
    output logic [63:0]      mem_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        {mem_req, mem_write, mem_special, mem_be} = 11'h0;
        mem_addr = 32'h0;
        mem_wdata = 64'h0;
    end

    // One cycle held to the taking edge; released address and data show inverted values
    task automatic access(input logic sp, input logic [31:0] addr, input logic wr,
                          input logic [7:0] be, input logic [63:0] wd,
                          output logic [63:0] rd, output logic ok);
        int n;
        @(posedge clk);
        mem_req <= 1'b1;
        mem_write <= wr;
        mem_special <= sp;
        mem_addr <= addr;
        mem_be <= be;
        mem_wdata <= wd;
        @(posedge clk);
        mem_req <= 1'b0;
        mem_addr <= ~addr;
        mem_wdata <= ~wd;
        #1;
        rd = 64'h0;
        ok = wr;
        // Answer bounded to a few cycles
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (rd_valid === 1'b1)
            begin
                rd = rd_data;
                ok = 1'b1;
            end
            else
                @(posedge clk) #1;
        end
    endtask : access
endmodule : slc_host

// [dv/slc_regs_bench.sv]
// Self-checking bench for the secure-launch register bank.
// Assumes slc_pkg and the slc_host thread model are compiled first.
module slc_regs_bench;
    import slc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, mem_req, mem_write, mem_special, rd_valid, ok;
    logic        plat_req, remap_lock, base_lock, mem_block, poisoned;
    logic [2:0]  rst_v;
    logic [6:0]  evt;
    logic [7:0]  mem_be;
    logic [31:0] mem_addr;
    logic [63:0] mem_wdata, rd_data, got;
    int          bad_count, checks_done;

    slc_regs slc_regs_inst (.clk(clk), .sys_rst(rst_v[0]), .pci_rst(rst_v[1]),
        .pwrgood_rst(rst_v[2]), .mem_req(mem_req), .mem_write(mem_write),
        .mem_special(mem_special), .mem_addr(mem_addr), .mem_be(mem_be),
        .mem_wdata(mem_wdata), .memcfg_lock_evt(evt[0]), .alias_fault_evt(evt[1]),
        .illegal_dram_read_evt(evt[2]), .improper_exit_evt(evt[3]),
        .poison_cycle_evt(evt[4]), .ack_secrets_held(evt[5]), .ack_no_secrets(evt[6]),
        .rd_valid(rd_valid), .rd_data(rd_data), .platform_reset_req(plat_req),
        .remap_lock(remap_lock), .base_lock(base_lock), .mem_block(mem_block),
        .poisoned(poisoned));
    slc_host slc_host_inst (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
        .mem_req(mem_req), .mem_write(mem_write), .mem_special(mem_special),
        .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // Window 0 special, 1 ordinary private, 2 public
    task automatic acc(input int w, input logic [15:0] off, input logic wr,
                       input logic [7:0] be, input logic [63:0] wd);
        slc_host_inst.access(w == 0, {(w == 2) ? SLC_PUB_BASE : SLC_PRIV_BASE, off},
                             wr, be, wd, got, ok);
        if (!ok)
        begin
            bad_count++;
            conclude();
        end
    endtask : acc

    task automatic wr(input int w, input logic [15:0] off, input logic [7:0] be,
                      input logic [63:0] d);
        acc(w, off, 1'b1, be, d);
    endtask : wr

    task automatic rd(input int w, input logic [15:0] off, input string name,
                      input logic [63:0] exp);
        acc(w, off, 1'b0, 8'hff, 64'h0);
        check(name, got, exp);
    endtask : rd

    // One-cycle pulses on event and reset inputs
    task automatic pulse(input int i);
        @(posedge clk);
        evt <= 7'h1 << i;
        @(posedge clk);
        evt <= 7'h0;
    endtask : pulse

    task automatic kick(input int k);
        @(posedge clk);
        rst_v <= 3'h1 << k;
        @(posedge clk);
        rst_v <= 3'h0;
    endtask : kick

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        conclude();
    end

    // Main sequence
    initial
    begin
        rst_v = 3'h7;
        evt = 7'h0;
        bad_count = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst_v <= 3'h0;
        rd(0, SLC_OFF_STATUS, "status", 64'h2);
        rd(2, SLC_OFF_ERROR, "error", 64'h0);
        rd(0, SLC_OFF_VERSION, "version", {56'h0, SLC_VERSION_DEF});
        rd(2, SLC_OFF_VERSION, "public version", 64'h0);
        $display("test reset done");
        wr(0, SLC_OFF_PRES_SET, 8'hff, 64'h3);
        wr(0, SLC_OFF_PRESENT, 8'hff, 64'hf0);
        rd(2, SLC_OFF_PRESENT, "present", 64'h3);
        wr(0, SLC_OFF_JOIN_SET, 8'hff, 64'h1);
        rd(0, SLC_OFF_STATUS, "status partial", 64'h0);
        wr(0, SLC_OFF_JOIN_SET, 8'hff, 64'h2);
        rd(0, SLC_OFF_STATUS, "status entered", 64'h1);
        rd(2, SLC_OFF_JOINED, "joined", 64'h3);
        wr(0, SLC_OFF_PRES_CLR, 8'hff, 64'h2);
        rd(0, SLC_OFF_STATUS, "status differ", 64'h0);
        wr(0, SLC_OFF_JOIN_CLR, 8'hff, 64'h3);
        rd(0, SLC_OFF_STATUS, "status exited", 64'h2);
        $display("test threads done");
        wr(0, SLC_OFF_ERR_SET, 8'hff, 64'hff);
        rd(2, SLC_OFF_ERROR, "error set", 64'h1c);
        for (int i = 1; i < 6; i++)
            pulse(i);
        rd(2, SLC_OFF_ERROR, "error events", 64'h7f);
        check("poisoned", {63'h0, poisoned}, 64'h1);
        pulse(6);
        rd(2, SLC_OFF_ERROR, "no secrets", 64'h3f);
        pulse(5);
        kick(0);
        rd(2, SLC_OFF_ERROR, "error kept", 64'h7f);
        check("mem_block", {63'h0, mem_block}, 64'h1);
        wr(0, SLC_OFF_MEM_ENABLE, SLC_BE_BYTE0, 64'h1);
        repeat (2) @(posedge clk);
        check("mem_block", {63'h0, mem_block}, 64'h0);
        wr(2, SLC_OFF_ERROR, 8'hff, 64'hff);
        rd(0, SLC_OFF_ERROR, "public clear", 64'h7f);
        wr(0, SLC_OFF_ERROR, 8'hff, 64'hff);
        rd(0, SLC_OFF_ERROR, "w1c", 64'h1);
        pulse(2);
        rd(0, SLC_OFF_ERROR, "dram read", 64'h5);
        $display("test errors done");
        wr(2, SLC_OFF_SCRATCH, 8'h0f, 64'h12345678);
        rd(0, SLC_OFF_SCRATCH, "public scratch", 64'h0);
        wr(0, SLC_OFF_SCRATCH, 8'h0f, 64'h89abcdef);
        wr(0, SLC_OFF_SCRATCH, 8'h02, 64'h5500);
        rd(2, SLC_OFF_SCRATCH, "scratch", 64'h89ab55ef);
        rd(1, SLC_OFF_STATUS, "closed", 64'h0);
        wr(1, SLC_OFF_PRIV_OPEN, SLC_BE_BYTE0, 64'h0);
        rd(0, SLC_OFF_STATUS, "still shut", 64'h2);
        wr(0, SLC_OFF_PRIV_OPEN, SLC_BE_BYTE0, 64'h0);
        rd(1, SLC_OFF_STATUS, "opened", 64'h82);
        wr(1, SLC_OFF_SCRATCH, 8'h0f, 64'h0badf00d);
        rd(2, SLC_OFF_SCRATCH, "private scratch", 64'h0badf00d);
        wr(1, SLC_OFF_PRIV_CLOSE, SLC_BE_BYTE0, 64'h0);
        rd(1, SLC_OFF_STATUS, "reclosed", 64'h0);
        rd(0, SLC_OFF_STATUS, "open flag", 64'h2);
        $display("test windows done");
        wr(2, SLC_OFF_PLAT_RST, SLC_BE_BYTE0, 64'h0);
        check("public reset", {63'h0, plat_req}, 64'h0);
        wr(0, SLC_OFF_PLAT_RST, 8'h03, 64'h0);
        check("wide reset", {63'h0, plat_req}, 64'h0);
        wr(0, SLC_OFF_PLAT_RST, SLC_BE_BYTE0, 64'h0);
        check("reset pulse", {63'h0, plat_req}, 64'h1);
        @(posedge clk) #1;
        check("reset end", {63'h0, plat_req}, 64'h0);
        wr(0, SLC_OFF_BASE_LOCK, SLC_BE_BYTE0, 64'h0);
        rd(0, SLC_OFF_STATUS, "base locked", 64'h22);
        check("base_lock", {63'h0, base_lock}, 64'h1);
        wr(0, SLC_OFF_BASE_UNLK, SLC_BE_BYTE0, 64'h0);
        rd(0, SLC_OFF_STATUS, "base unlocked", 64'h2);
        pulse(0);
        rd(0, SLC_OFF_STATUS, "cfg locked", 64'h42);
        check("remap_lock", {63'h0, remap_lock}, 64'h1);
        wr(0, SLC_OFF_MCFG_CHK, SLC_BE_BYTE0, 64'h0);
        rd(0, SLC_OFF_STATUS, "cfg checked", 64'h842);
        kick(1);
        rd(0, SLC_OFF_STATUS, "pci reset", 64'h42);
        wr(0, SLC_OFF_MCFG_CHK, SLC_BE_BYTE0, 64'h0);
        wr(0, SLC_OFF_MCFG_UNLK, SLC_BE_BYTE0, 64'h0);
        rd(0, SLC_OFF_STATUS, "cfg unlocked", 64'h2);
        pulse(0);
        kick(0);
        rd(0, SLC_OFF_STATUS, "sys reset", 64'h2);
        kick(2);
        rd(2, SLC_OFF_ERROR, "power error", 64'h0);
        rd(2, SLC_OFF_SCRATCH, "power scratch", 64'h0);
        check("poison cleared", {63'h0, poisoned}, 64'h0);
        $display("test commands done");
        conclude();
    end
endmodule : slc_regs_bench
